// file: hw/skf_pkg.sv
package skf_pkg;
	// =========================================
	// register map
	localparam logic [2:0] ADDR_CONFIG     = 3'h0;
	localparam logic [2:0] ADDR_HALF_SEL   = 3'h1;
	localparam logic [2:0] ADDR_MOM_SEL    = 3'h2;
	localparam logic [2:0] ADDR_OVR_SEL    = 3'h3;
	localparam logic [2:0] ADDR_KEYS_LO    = 3'h4;
	localparam logic [2:0] ADDR_KEYS_HI    = 3'h5;
	localparam logic [2:0] ADDR_STATUS     = 3'h6;
	localparam logic [7:0] CONFIG_RESET    = 8'h00;
	localparam logic [4:0] SEL_RESET       = 5'h00;
	localparam logic [4:0] SEL_MAX         = 5'h13;
	// =========================================
	// config bit positions
	localparam int BIT_EFF_LO  = 0;
	localparam int BIT_EFF_HI  = 1;
	localparam int BIT_MOM_F4  = 2;
	localparam int BIT_HALF_F7 = 3;
	localparam int BIT_HALF_F3 = 4;
	localparam int BIT_DC_STOP = 5;
	localparam int BIT_MOM_F3  = 6;
	localparam int BIT_AUX_OUT = 7;
	// =========================================
	// key numbers
	localparam logic [4:0] KEY_THREE = 5'h03;
	localparam logic [4:0] KEY_FOUR  = 5'h04;
	localparam logic [4:0] KEY_SEVEN = 5'h07;
	localparam int NUM_KEYS = 20;
	// =========================================
	// momentum effect codes
	typedef enum logic [1:0] {
		SKF_EFF_NONE  = 2'b00,
		SKF_EFF_EXP   = 2'b01,
		SKF_EFF_QUART = 2'b10,
		SKF_EFF_ALL   = 2'b11
	} skf_eff_e;
	// =========================================
	// status bit positions
	localparam int ST_HALF   = 0;
	localparam int ST_MOM    = 1;
	localparam int ST_OVR    = 2;
	localparam int ST_HALF_V = 3;
	localparam int ST_MOM_V  = 4;
endpackage

// file: hw/skf_key_pick.sv
`timescale 1ns/1ps
// selects one key level from the key vector; valid low means no key
module skf_key_pick #(
	parameter int N_KEYS = 20
) (
	input  wire logic [N_KEYS-1:0] i_keys,
	input  wire logic [4:0]        i_num,
	input  wire logic              i_valid,
	output logic                   o_on
);
	if (N_KEYS < 8 || N_KEYS > 32) begin : g_bad_keys
		$error("N_KEYS out of range");
	end
	always_comb begin
		o_on = 1'b0;
		if (i_valid && (int'(i_num) < N_KEYS)) begin
			o_on = i_keys[i_num];
		end
	end
endmodule // skf_key_pick

// file: hw/skf_speed_scale.sv
`timescale 1ns/1ps
// halves throttle and scales momentum times per effect code
module skf_speed_scale #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] i_throttle,
	input  wire logic         i_half,
	input  wire logic [1:0]   i_eff,
	input  wire logic         i_mom_on,
	input  wire logic [7:0]   i_accel,
	input  wire logic [7:0]   i_decel,
	input  wire logic [7:0]   i_exp_accel,
	input  wire logic [7:0]   i_exp_decel,
	output logic      [W-1:0] o_throttle,
	output logic      [7:0]   o_accel,
	output logic      [7:0]   o_decel,
	output logic      [7:0]   o_exp_accel,
	output logic      [7:0]   o_exp_decel
);
	if (W < 2) begin : g_bad_width
		$error("W too small");
	end
	always_comb begin
		o_throttle  = i_half ? (i_throttle >> 1) : i_throttle;
		o_accel     = i_accel;
		o_decel     = i_decel;
		o_exp_accel = i_exp_accel;
		o_exp_decel = i_exp_decel;
		if (i_mom_on) begin
			case (i_eff)
				skf_pkg::SKF_EFF_NONE: begin
				end
				skf_pkg::SKF_EFF_EXP: begin
					o_exp_accel = 8'h00;
					o_exp_decel = 8'h00;
				end
				skf_pkg::SKF_EFF_QUART: begin
					o_accel = i_accel >> 2;
					o_decel = i_decel >> 2;
				end
				skf_pkg::SKF_EFF_ALL: begin
					o_accel     = 8'h00;
					o_decel     = 8'h00;
					o_exp_accel = 8'h00;
					o_exp_decel = 8'h00;
				end
				default: begin
				end
			endcase
		end
	end
endmodule // skf_speed_scale

// file: hw/skf_shunting_ctrl.sv
`timescale 1ns/1ps
module skf_shunting_ctrl #(
	parameter int THROTTLE_W = 8
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	input  wire logic [2:0]            i_addr,
	input  wire logic [7:0]            i_wdata,
	input  wire logic                  i_wr,
	input  wire logic                  i_rd,
	output logic      [7:0]            o_rdata,
	input  wire logic [19:0]           i_fn_keys,
	input  wire logic                  i_signal_override_key,
	input  wire logic [THROTTLE_W-1:0] i_throttle,
	input  wire logic [7:0]            i_base_accel_time,
	input  wire logic [7:0]            i_base_decel_time,
	input  wire logic [7:0]            i_exponential_accel_shape,
	input  wire logic [7:0]            i_exponential_decel_shape,
	output logic      [THROTTLE_W-1:0] o_throttle,
	output logic      [7:0]            o_accel_time,
	output logic      [7:0]            o_decel_time,
	output logic      [7:0]            o_exp_accel_shape,
	output logic      [7:0]            o_exp_decel_shape,
	output logic                       o_half_speed_on,
	output logic                       o_momentum_key_on,
	output logic                       o_signal_override_function,
	output logic                       o_dc_stop_enable,
	output logic                       o_aux_pins_as_outputs
);
	if (THROTTLE_W < 2 || THROTTLE_W > 16) begin : g_bad_width
		$error("THROTTLE_W out of range");
	end

	// =========================================
	// registers
	logic [7:0]  shunting_key_config;
	logic [4:0]  half_speed_key_select;
	logic [4:0]  momentum_key_select;
	logic [4:0]  override_key_select;
	logic        sel_ok;

	// select writes beyond the last key are dropped
	assign sel_ok = (i_wdata <= 8'(skf_pkg::SEL_MAX));

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			shunting_key_config <= skf_pkg::CONFIG_RESET;
		end else if (i_wr && (i_addr == skf_pkg::ADDR_CONFIG)) begin
			shunting_key_config <= i_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			half_speed_key_select <= skf_pkg::SEL_RESET;
		end else if (i_wr && sel_ok && (i_addr == skf_pkg::ADDR_HALF_SEL)) begin
			half_speed_key_select <= i_wdata[4:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			momentum_key_select <= skf_pkg::SEL_RESET;
		end else if (i_wr && sel_ok && (i_addr == skf_pkg::ADDR_MOM_SEL)) begin
			momentum_key_select <= i_wdata[4:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			override_key_select <= skf_pkg::SEL_RESET;
		end else if (i_wr && sel_ok && (i_addr == skf_pkg::ADDR_OVR_SEL)) begin
			override_key_select <= i_wdata[4:0];
		end
	end

	// =========================================
	// key pin synchroniser
	logic [19:0] keys_meta;
	logic [19:0] keys_sync;
	logic        ovr_meta;
	logic        ovr_sync;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			keys_meta <= 20'h00000;
			keys_sync <= 20'h00000;
		end else begin
			keys_meta <= i_fn_keys;
			keys_sync <= keys_meta;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ovr_meta <= 1'b0;
			ovr_sync <= 1'b0;
		end else begin
			ovr_meta <= i_signal_override_key;
			ovr_sync <= ovr_meta;
		end
	end

	// =========================================
	// key selection
	logic       bit_h3;
	logic       bit_h7;
	logic [4:0] half_num;
	logic       half_valid;
	logic [4:0] mom_num;
	logic       mom_valid;
	logic       mom_uses_ovr;

	assign bit_h3 = shunting_key_config[skf_pkg::BIT_HALF_F3];
	assign bit_h7 = shunting_key_config[skf_pkg::BIT_HALF_F7];

	always_comb begin
		half_num   = 5'h00;
		half_valid = 1'b0;
		if (half_speed_key_select != 5'h00) begin
			half_num   = half_speed_key_select;
			half_valid = 1'b1;
		end else if (bit_h3 && !bit_h7) begin
			half_num   = skf_pkg::KEY_THREE;
			half_valid = 1'b1;
		end else if (bit_h7 && !bit_h3) begin
			half_num   = skf_pkg::KEY_SEVEN;
			half_valid = 1'b1;
		end
	end

	always_comb begin
		mom_num      = 5'h00;
		mom_valid    = 1'b0;
		mom_uses_ovr = 1'b0;
		if (momentum_key_select != 5'h00) begin
			mom_num   = momentum_key_select;
			mom_valid = 1'b1;
		end else if (shunting_key_config[skf_pkg::BIT_MOM_F3]) begin
			mom_num   = skf_pkg::KEY_THREE;
			mom_valid = 1'b1;
		end else if (shunting_key_config[skf_pkg::BIT_MOM_F4]) begin
			mom_num   = skf_pkg::KEY_FOUR;
			mom_valid = 1'b1;
		end else begin
			mom_uses_ovr = 1'b1;
		end
	end

	logic half_key;
	logic mom_key_fn;
	logic ovr_key_fn;
	logic mom_key;
	logic ovr_fn;

	skf_key_pick #(.N_KEYS(skf_pkg::NUM_KEYS)) u_half (
		.i_keys  (keys_sync),
		.i_num   (half_num),
		.i_valid (half_valid),
		.o_on    (half_key)
	);
	skf_key_pick #(.N_KEYS(skf_pkg::NUM_KEYS)) u_mom (
		.i_keys  (keys_sync),
		.i_num   (mom_num),
		.i_valid (mom_valid),
		.o_on    (mom_key_fn)
	);
	skf_key_pick #(.N_KEYS(skf_pkg::NUM_KEYS)) u_ovr (
		.i_keys  (keys_sync),
		.i_num   (override_key_select),
		.i_valid (override_key_select != 5'h00),
		.o_on    (ovr_key_fn)
	);

	// legacy default rides on the dedicated key
	assign mom_key = mom_uses_ovr ? ovr_sync : mom_key_fn;
	assign ovr_fn  = ovr_sync | ovr_key_fn;

	// =========================================
	// scaling
	logic [THROTTLE_W-1:0] next_throttle;
	logic [7:0]            next_accel;
	logic [7:0]            next_decel;
	logic [7:0]            next_exp_accel;
	logic [7:0]            next_exp_decel;

	skf_speed_scale #(.W(THROTTLE_W)) u_scale (
		.i_throttle  (i_throttle),
		.i_half      (half_key),
		.i_eff       (shunting_key_config[skf_pkg::BIT_EFF_HI:skf_pkg::BIT_EFF_LO]),
		.i_mom_on    (mom_key),
		.i_accel     (i_base_accel_time),
		.i_decel     (i_base_decel_time),
		.i_exp_accel (i_exponential_accel_shape),
		.i_exp_decel (i_exponential_decel_shape),
		.o_throttle  (next_throttle),
		.o_accel     (next_accel),
		.o_decel     (next_decel),
		.o_exp_accel (next_exp_accel),
		.o_exp_decel (next_exp_decel)
	);

	// =========================================
	// registered outputs
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_throttle        <= '0;
			o_accel_time      <= 8'h00;
			o_decel_time      <= 8'h00;
			o_exp_accel_shape <= 8'h00;
			o_exp_decel_shape <= 8'h00;
		end else begin
			o_throttle        <= next_throttle;
			o_accel_time      <= next_accel;
			o_decel_time      <= next_decel;
			o_exp_accel_shape <= next_exp_accel;
			o_exp_decel_shape <= next_exp_decel;
		end
	end

	// =========================================
	// key levels and mode flags
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_half_speed_on   <= 1'b0;
			o_momentum_key_on <= 1'b0;
		end else begin
			o_half_speed_on   <= half_key;
			o_momentum_key_on <= mom_key;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_signal_override_function <= 1'b0;
			o_dc_stop_enable           <= 1'b0;
			o_aux_pins_as_outputs      <= 1'b0;
		end else begin
			o_signal_override_function <= ovr_fn;
			o_dc_stop_enable           <= shunting_key_config[skf_pkg::BIT_DC_STOP];
			o_aux_pins_as_outputs      <= shunting_key_config[skf_pkg::BIT_AUX_OUT];
		end
	end

	// =========================================
	// status word
	logic [7:0] status_word;

	always_comb begin
		status_word                     = 8'h00;
		status_word[skf_pkg::ST_HALF]   = half_key;
		status_word[skf_pkg::ST_MOM]    = mom_key;
		status_word[skf_pkg::ST_OVR]    = ovr_fn;
		status_word[skf_pkg::ST_HALF_V] = half_valid;
		status_word[skf_pkg::ST_MOM_V]  = mom_valid;
	end

	// =========================================
	// read port, data stands one cycle then clears
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			case (i_addr)
				skf_pkg::ADDR_CONFIG: begin
					o_rdata <= shunting_key_config;
				end
				skf_pkg::ADDR_HALF_SEL: begin
					o_rdata <= {3'h0, half_speed_key_select};
				end
				skf_pkg::ADDR_MOM_SEL: begin
					o_rdata <= {3'h0, momentum_key_select};
				end
				skf_pkg::ADDR_OVR_SEL: begin
					o_rdata <= {3'h0, override_key_select};
				end
				skf_pkg::ADDR_KEYS_LO: begin
					o_rdata <= keys_sync[7:0];
				end
				skf_pkg::ADDR_KEYS_HI: begin
					o_rdata <= keys_sync[15:8];
				end
				skf_pkg::ADDR_STATUS: begin
					o_rdata <= status_word;
				end
				default: begin
					o_rdata <= 8'h00;
				end
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end
endmodule // skf_shunting_ctrl

// file: verif/skf_shunting_ctrl_assertions.sv
`timescale 1ns/1ps
// =========================================
// output checks
module skf_chk #(
	parameter int THROTTLE_W = 8
) (
	input wire logic                  i_clk,
	input wire logic                  i_rst,
	input wire logic [2:0]            i_addr,
	input wire logic [7:0]            i_wdata,
	input wire logic                  i_wr,
	input wire logic [THROTTLE_W-1:0] i_throttle,
	input wire logic [7:0]            i_base_accel_time,
	input wire logic [7:0]            i_base_decel_time,
	input wire logic [7:0]            i_exponential_accel_shape,
	input wire logic [THROTTLE_W-1:0] o_throttle,
	input wire logic [7:0]            o_accel_time,
	input wire logic [7:0]            o_decel_time,
	input wire logic [7:0]            o_exp_accel_shape,
	input wire logic                  o_half_speed_on,
	input wire logic                  o_momentum_key_on,
	input wire logic                  o_dc_stop_enable,
	input wire logic                  o_aux_pins_as_outputs
);
	logic                  rst_q;
	logic [7:0]            cfg_q;
	logic [1:0]            eff;
	logic [7:0]            acc, dec, xac;
	logic [THROTTLE_W-1:0] thr;
	wire logic             cw  = i_wr && i_addr == 3'h0;
	wire logic             mom = !rst_q && o_momentum_key_on;
	// shadow of the config register, in step with it; eff lags it by one cycle
	always_ff @(posedge i_clk) begin
		rst_q <= i_rst;
		eff <= cfg_q[1:0];
		acc <= i_base_accel_time;
		dec <= i_base_decel_time;
		xac <= i_exponential_accel_shape;
		thr <= i_throttle;
		cfg_q <= i_rst ? 8'h00 : (cw ? i_wdata : cfg_q);
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	property p_none;
		mom && eff == 2'b00 |-> o_accel_time == acc && o_exp_accel_shape == xac;
	endproperty
	a_none: assert property (p_none) else $error("effect none wrong");
	property p_exp;
		mom && eff == 2'b01 |-> o_accel_time == acc && o_exp_accel_shape == 8'h00;
	endproperty
	a_exp: assert property (p_exp) else $error("effect exp wrong");
	property p_quart;
		mom && eff == 2'b10 |-> o_accel_time == acc >> 2 && o_decel_time == dec >> 2;
	endproperty
	a_quart: assert property (p_quart) else $error("effect quarter wrong");
	property p_all;
		mom && eff == 2'b11 |-> o_accel_time == 8'h00 && o_exp_accel_shape == 8'h00;
	endproperty
	a_all: assert property (p_all) else $error("effect all wrong");
	property p_half;
		!rst_q |-> o_throttle == (o_half_speed_on ? thr >> 1 : thr);
	endproperty
	a_half: assert property (p_half) else $error("throttle scale wrong");
	property p_rel;
		!rst_q && !o_momentum_key_on |-> o_accel_time == acc && o_decel_time == dec;
	endproperty
	a_rel: assert property (p_rel) else $error("momentum not restored");
	property p_dc;
		cw ##1 !cw |=> o_dc_stop_enable == $past(i_wdata[5], 2);
	endproperty
	a_dc: assert property (p_dc) else $error("dc stop flag wrong");
	property p_aux;
		cw ##1 !cw |=> o_aux_pins_as_outputs == $past(i_wdata[7], 2);
	endproperty
	a_aux: assert property (p_aux) else $error("aux pin flag wrong");
	c_half: cover property (o_half_speed_on);
	c_all: cover property (mom && eff == 2'b11);
	c_bits: cover property (o_dc_stop_enable && o_aux_pins_as_outputs);
endmodule // skf_chk

bind skf_shunting_ctrl skf_chk #(.THROTTLE_W(THROTTLE_W)) skf_chk_i (.i_clk, .i_rst,
	.i_addr, .i_wdata, .i_wr, .i_throttle, .i_base_accel_time, .i_base_decel_time,
	.i_exponential_accel_shape, .o_throttle, .o_accel_time, .o_decel_time,
	.o_exp_accel_shape, .o_half_speed_on, .o_momentum_key_on, .o_dc_stop_enable,
	.o_aux_pins_as_outputs);

// file: verif/skf_cab_model.sv
`timescale 1ns/1ps
// =========================================
// cab side: function key levels
module skf_cab_model (
	input  wire logic        i_clk,
	output logic      [19:0] o_fn_keys,
	output logic             o_signal_override_key
);
	initial begin
		o_fn_keys = 20'h00000;
		o_signal_override_key = 1'b0;
	end
	// key 20 is the dedicated override key
	task automatic set_key(input int n, input logic v);
		@(posedge i_clk);
		if (n == 20)
			o_signal_override_key <= v;
		else
			o_fn_keys[n] <= v;
	endtask
endmodule // skf_cab_model

// file: verif/test_shunting_key_function_control.sv
`timescale 1ns/1ps
module test_shunting_key_function_control;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic [2:0]  i_addr = 3'h0;
	logic [7:0]  i_wdata = 8'h00;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic [19:0] i_fn_keys;
	logic        i_signal_override_key;
	logic [7:0]  i_throttle = 8'hc9;
	logic [7:0]  i_base_accel_time = 8'h37;
	logic [7:0]  i_base_decel_time = 8'h5e;
	logic [7:0]  i_exponential_accel_shape = 8'h21;
	logic [7:0]  i_exponential_decel_shape = 8'h42;
	logic [7:0]  o_rdata, o_throttle, o_accel_time, o_decel_time;
	logic [7:0]  o_exp_accel_shape, o_exp_decel_shape;
	logic        o_half_speed_on, o_momentum_key_on, o_signal_override_function;
	logic        o_dc_stop_enable, o_aux_pins_as_outputs;
	int          err_count = 0;
	int          samples_checked = 0;
	always #20 i_clk = ~i_clk;
	skf_shunting_ctrl skf_shunting_ctrl_i (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .i_fn_keys, .i_signal_override_key, .i_throttle, .i_base_accel_time,
		.i_base_decel_time, .i_exponential_accel_shape, .i_exponential_decel_shape,
		.o_throttle, .o_accel_time, .o_decel_time, .o_exp_accel_shape, .o_exp_decel_shape,
		.o_half_speed_on, .o_momentum_key_on, .o_signal_override_function,
		.o_dc_stop_enable, .o_aux_pins_as_outputs);
	skf_cab_model skf_cab_model_i (.i_clk, .o_fn_keys(i_fn_keys),
		.o_signal_override_key(i_signal_override_key));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, exp);
	endtask
	task automatic hold(input int k, input logic v);
		skf_cab_model_i.set_key(k, v);
		repeat (4) @(posedge i_clk);
		#1;
	endtask
	task automatic t_reset;
		for (int a = 0; a < 8; a++)
			rd(a[2:0], 8'h00);
		chk({6'h00, o_dc_stop_enable, o_aux_pins_as_outputs}, 8'h00);
	endtask
	task automatic t_half;
		logic [7:0] cfg [3] = '{8'h10, 8'h08, 8'h18};
		logic       e;
		for (int i = 0; i < 3; i++) begin
			wr(3'h0, cfg[i]);
			for (int k = 3; k < 8; k += 4) begin
				hold(k, 1'b1);
				e = (i == 0 && k == 3) || (i == 1 && k == 7);
				chk({7'h00, o_half_speed_on}, {7'h00, e});
				chk(o_throttle, e ? 8'h64 : 8'hc9);
				hold(k, 1'b0);
			end
		end
	endtask
	task automatic t_mom;
		logic [7:0] cfg [4] = '{8'h03, 8'h07, 8'h47, 8'h43};
		int         key [4] = '{20, 4, 3, 3};
		int         bad [4] = '{3, 3, 4, 4};
		logic [7:0] acc [4] = '{8'h37, 8'h37, 8'h0d, 8'h00};
		logic [7:0] dec [4] = '{8'h5e, 8'h5e, 8'h17, 8'h00};
		logic [7:0] xa  [4] = '{8'h21, 8'h00, 8'h21, 8'h00};
		for (int i = 0; i < 4; i++) begin
			wr(3'h0, cfg[i]);
			hold(bad[i], 1'b1);
			chk({7'h00, o_momentum_key_on}, 8'h00);
			hold(bad[i], 1'b0);
			hold(key[i], 1'b1);
			chk({7'h00, o_momentum_key_on}, 8'h01);
			chk(o_accel_time, 8'h00);
			hold(key[i], 1'b0);
		end
		hold(4, 1'b1);
		for (int e = 0; e < 4; e++) begin
			wr(3'h0, 8'h04 | e[7:0]);
			hold(4, 1'b1);
			chk(o_accel_time, acc[e]);
			chk(o_decel_time, dec[e]);
			chk(o_exp_accel_shape, xa[e]);
			chk(o_exp_decel_shape, xa[e] << 1);
		end
		hold(4, 1'b0);
		chk(o_accel_time, 8'h37);
		chk(o_exp_decel_shape, 8'h42);
	endtask
	task automatic t_sel;
		wr(3'h1, 8'h09);
		wr(3'h0, 8'h10);
		hold(3, 1'b1);
		chk({7'h00, o_half_speed_on}, 8'h00);
		hold(9, 1'b1);
		chk({7'h00, o_half_speed_on}, 8'h01);
		rd(3'h6, 8'h09);
		rd(3'h5, 8'h02);
		rd(3'h4, 8'h08);
		hold(3, 1'b0);
		hold(9, 1'b0);
		wr(3'h1, 8'h14);
		rd(3'h1, 8'h09);
		wr(3'h1, 8'h13);
		rd(3'h1, 8'h13);
		wr(3'h2, 8'h0c);
		wr(3'h0, 8'h07);
		hold(4, 1'b1);
		chk({7'h00, o_momentum_key_on}, 8'h00);
		hold(12, 1'b1);
		chk(o_decel_time, 8'h00);
		hold(4, 1'b0);
		hold(12, 1'b0);
		wr(3'h3, 8'h05);
		hold(5, 1'b1);
		chk({7'h00, o_signal_override_function}, 8'h01);
		hold(5, 1'b0);
		chk({7'h00, o_signal_override_function}, 8'h00);
	endtask
	task automatic t_bits;
		wr(3'h0, 8'ha0);
		wr(3'h0, 8'h20);
		rd(3'h0, 8'h20);
		chk({6'h00, o_dc_stop_enable, o_aux_pins_as_outputs}, 8'h02);
		wr(3'h0, 8'h80);
		rd(3'h0, 8'h80);
		chk({6'h00, o_dc_stop_enable, o_aux_pins_as_outputs}, 8'h01);
	endtask
	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b0;
		t_reset();
		t_half();
		t_mom();
		t_sel();
		t_bits();
		give_verdict();
	end
	initial begin
		repeat (5000) @(posedge i_clk);
		err_count++;
		give_verdict();
	end
endmodule // test_shunting_key_function_control
